// File: logic/status_indicator_consts.vh
/*
  Constants for the status indicator and fault bookkeeping block.
  Assumes inclusion by bare name from the logic folder; definitions only.
*/
`ifndef STATUS_INDICATOR_CONSTS_VH
`define STATUS_INDICATOR_CONSTS_VH

// Clock rate and flash timing
`define CLK_PERIOD_PS      32'd5000
`define FLASH_HALF_MS      32'd250
`define FLASH_HALF_CYCLES  ((`FLASH_HALF_MS * 32'd1000000) / (`CLK_PERIOD_PS / 32'd1000))

// Error code word
`define ERR_CODE_W         16
`define ERR_CODE_RST       16'h0000
`define USER_CODE_LO       16'hFF00
`define USER_CODE_HI       16'hFF0F

// Mode state codes
`define MODE_PROGRAM       2'h0
`define MODE_RUN           2'h1
`define MODE_TEST          2'h2
`define MODE_FAULTED       2'h3

`endif

// File: logic/status_indicator_fault_logic.v
/*
  Front-panel indicator drive plus major-fault bookkeeping: error code
  word, halted flag, power-up override, run entry and user fault dispatch.
  Assumes all status inputs come from logic on clk, except the point inputs,
  which arrive from pins and are synchronised here. Power-up is rst_n.
*/
// Behaviour
// - Power lamp green when power good
// - Run lamp steady in run or remote-run
// - Run lamp flashes during memory-module transfer
// - Fault lamp off, flash user, steady hardware
// - Force lamp lit while any force installed
// - Battery lamp red while battery low
// - Port lamps flash during port activity
// - Default-comm lamp follows channel 0 defaults
// - Point lamps follow point logic state
// - Hardware error lights power and fault; no power darkens all
// - Major fault records code, flashes fault lamp
// - Halted flag blocks run entry until cleared
// - Override bit clears fault at power cycle
// - Override plus mode bit enters run at power-up
// - Persisting fault re-faults after power cycle
// - User fault calls subroutine; cleared flag resumes
// - Non-user faults never call subroutine
`timescale 1ns/1ps
`include "status_indicator_consts.vh"

// Operation in brief
// Every lamp is a registered level, high means lit. A dead or overloaded
// supply darkens the whole panel at once, whatever the state behind it.
// The flash phase is shared, so all flashing lamps blink together.
// Mode codes: program, run, test, faulted; see the constants header.
// The halted flag is the single gate on run entry out of faulted.
// Power cycle is modelled by rst_n; persistence of a fault across it is
// reported by fault_still_present, since this block keeps no state there.
// Limitation: override settings only matter in the boot cycle, which
// makes a mid-run change of them harmless.
// Inputs marked as pulses are one-cycle strobes from logic on clk.
// Requests are honoured from the second edge after reset release.
// run_refused answers in the same cycle as the refused request.

module status_indicator_fault_logic #(
  parameter N_IN        = 16,                 // Input point count
  parameter N_OUT       = 12,                 // Output point count
  parameter DUAL_PORT   = 1,                  // Second channel fitted
  parameter FLASH_HALF  = `FLASH_HALF_CYCLES  // Flash half period in cycles
) (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   power_good,
  input  wire                   supply_overload,
  input  wire                   hw_error,
  input  wire                   critical_fault,
  input  wire                   force_count_nz,
  input  wire                   battery_low,
  input  wire                   port0_active,
  input  wire                   port1_active,
  input  wire                   default_comm_ch0,
  input  wire                   mm_transfer,
  input  wire [N_IN-1:0]        input_points,
  input  wire [N_OUT-1:0]       output_points,
  input  wire                   remote_run_mode,
  input  wire                   run_request,
  input  wire                   test_request,
  input  wire                   program_request,
  input  wire                   major_fault,
  input  wire                   major_fault_user,
  input  wire                   major_fault_recoverable,
  input  wire [`ERR_CODE_W-1:0] fault_code,
  input  wire                   fault_still_present,
  input  wire                   fault_override_bit,
  input  wire                   mode_behavior_bit,
  input  wire                   code_wr,
  input  wire [`ERR_CODE_W-1:0] code_wr_data,
  input  wire                   halted_set,
  input  wire                   halted_clr,
  input  wire                   subroutine_done,
  output reg                    power_indicator,
  output reg                    run_indicator,
  output reg                    fault_indicator,
  output reg                    force_indicator,
  output reg                    battery_indicator,
  output reg                    port0_activity_indicator,
  output reg                    port1_activity_indicator,
  output reg                    default_comm_indicator,
  output reg  [N_IN-1:0]        input_indicators,
  output reg  [N_OUT-1:0]       output_indicators,
  output reg  [`ERR_CODE_W-1:0] major_error_code,
  output reg                    major_error_halted_flag,
  output reg                    user_fault_call,
  output reg  [1:0]             mode_state,
  output wire                   run_refused,
  output wire                   user_code_in_range
);

  // Internal state
  // Flash prescaler state
  reg [31:0]            flash_cnt_q;    // Half-period counter
  reg                   flash_q;        // Shared flash phase
  // Point input synchroniser
  reg [N_IN-1:0]        in_meta_q;      // First stage only
  reg [N_IN-1:0]        in_sync_q;      // Second stage
  // Fault bookkeeping
  reg                   user_fault_q;   // Latched fault is a user fault
  reg                   recoverable_q;  // Latched fault is recoverable
  reg                   in_sub_q;       // Subroutine in progress
  reg                   boot_q;         // First cycle after power-up
  reg [1:0]             resume_mode_q;  // Mode before the fault
  wire                  lamps_live;     // Supply able to light lamps
  wire                  hard_fault;     // Steady-red fault class
  wire                  run_like;       // Run or test mode
  // Note: flash_cnt_q is 32 bits; FLASH_HALF must stay below 2**32.

  // Combinational helpers; run_refused is a handshake answer and may be
  // combinational, unlike the lamps.
  assign lamps_live = power_good & ~supply_overload;
  assign hard_fault = hw_error | critical_fault;
  assign run_like   = (mode_state == `MODE_RUN) | (mode_state == `MODE_TEST);
  // Run entry refused while the halted flag stands
  assign run_refused = run_request & major_error_halted_flag;
  // Helper for software declaring its own faults
  assign user_code_in_range = (major_error_code >= `USER_CODE_LO) &&
                              (major_error_code <= `USER_CODE_HI);

  // Shared flash prescaler; one phase for every lamp keeps them in step
  // The counter is wide enough for the full half period at 200 MHz.
  // A shorter FLASH_HALF only shortens the blink, handy for simulation.
  // A counter rather than a clock divider keeps everything on clk.
  // Reset starts the phase dark so lamps do not flash on at power-up.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_q <= 32'h00000000;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q >= FLASH_HALF - 1) begin
      flash_cnt_q <= 32'h00000000;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h00000001;
    end
  end

  // Point inputs come from pins, so two stages first
  // Only in_sync_q is read elsewhere; in_meta_q may go metastable.
  // Costs two cycles of lamp latency, invisible to an operator.
  // Output points come from logic on clk and skip this stage.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q <= {N_IN{1'b0}};
      in_sync_q <= {N_IN{1'b0}};
    end else begin
      in_meta_q <= input_points;
      in_sync_q <= in_meta_q;
    end
  end

  // Fault bookkeeping and mode sequencing
  // Priority, highest first:
  //   boot cycle after power-up (override and persistence),
  //   a major fault event (hardware or software),
  //   software writes to the code word and halted flag,
  //   end of the user fault subroutine,
  //   operator mode requests.
  // A fault in the same cycle as a clear leaves the flag set, so a
  // clear can never swallow a fresh fault.
  // resume_mode_q remembers where to return after a recoverable fault;
  // it is not overwritten by a second fault while already faulted, so
  // the original run or test mode survives a fault cascade.
  // user_fault_call is a one-cycle strobe toward the subroutine runner.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      major_error_code        <= `ERR_CODE_RST;
      major_error_halted_flag <= 1'b0;
      user_fault_call         <= 1'b0;
      mode_state              <= `MODE_PROGRAM;
      user_fault_q            <= 1'b0;
      recoverable_q           <= 1'b0;
      in_sub_q                <= 1'b0;
      boot_q                  <= 1'b1;
      resume_mode_q           <= `MODE_PROGRAM;
    end else begin
      user_fault_call <= 1'b0;
      boot_q          <= 1'b0;
      if (boot_q) begin
        // Power-up: a persisting fault always wins
        // With neither override bit set and no persisting fault the reset
        // values already stand: program mode, flag clear.
        if (fault_still_present) begin
          major_error_halted_flag <= 1'b1;
          mode_state              <= `MODE_FAULTED;
        end else if (fault_override_bit & mode_behavior_bit) begin
          major_error_halted_flag <= 1'b0;
          mode_state              <= `MODE_RUN;
        end else if (fault_override_bit) begin
          // Override alone: clear the fault, stay in program
          major_error_halted_flag <= 1'b0;
          mode_state              <= `MODE_PROGRAM;
        end
      end else if (major_fault) begin
        // Record code and halt; only user faults dispatch the subroutine
        major_error_code        <= fault_code;
        major_error_halted_flag <= 1'b1;
        user_fault_q            <= major_fault_user;
        recoverable_q           <= major_fault_recoverable;
        if (mode_state != `MODE_FAULTED) begin
          resume_mode_q <= mode_state;
        end
        // Subroutine runs only from run or test; a fault in program or
        // already faulted mode just records the code.
        if (major_fault_user & run_like) begin
          user_fault_call <= 1'b1;
          in_sub_q        <= 1'b1;
        end else begin
          in_sub_q <= 1'b0;
        end
        mode_state <= `MODE_FAULTED;
      end else begin
        // Software writes to the code word and halted flag
        if (code_wr) begin
          major_error_code <= code_wr_data;
        end
        // Software-declared faults are user faults but never recoverable,
        // and no subroutine is dispatched for them.
        // Set outranks clear when both arrive together.
        if (halted_set) begin
          major_error_halted_flag <= 1'b1;
          if (mode_state != `MODE_FAULTED) begin
            resume_mode_q <= mode_state;
          end
          user_fault_q  <= 1'b1;
          recoverable_q <= 1'b0;
          mode_state    <= `MODE_FAULTED;
        end else if (halted_clr) begin
          major_error_halted_flag <= 1'b0;
        end
        // End of subroutine: resume only if recoverable and flag cleared
        // The flag may be cleared in this very cycle by halted_clr, hence
        // the look-ahead term; a set in the same cycle blocks resume.
        if (in_sub_q & subroutine_done) begin
          in_sub_q <= 1'b0;
          if (recoverable_q & user_fault_q &
              ~(major_error_halted_flag & ~halted_clr) & ~halted_set) begin
            mode_state <= resume_mode_q;
          end
        end else if (!halted_set) begin
          // Operator mode requests
          // Faulted mode leaves only by run entry with the flag clear;
          // a program request there is ignored on purpose.
          case (mode_state)
            `MODE_FAULTED: begin
              if (run_request & ~major_error_halted_flag) begin
                mode_state <= `MODE_RUN;
              end else if (program_request) begin
                mode_state <= `MODE_FAULTED;
              end
            end
            `MODE_PROGRAM: begin
              if (run_request) begin
                mode_state <= `MODE_RUN;
              end else if (test_request) begin
                mode_state <= `MODE_TEST;
              end
            end
            `MODE_RUN, `MODE_TEST: begin
              // Program wins over test, test over run
              if (program_request) begin
                mode_state <= `MODE_PROGRAM;
              end else if (test_request) begin
                mode_state <= `MODE_TEST;
              end else if (run_request) begin
                mode_state <= `MODE_RUN;
              end
            end
            default: begin
              // Unreachable with two-bit codes; kept as a safe landing
              mode_state <= `MODE_PROGRAM;
            end
          endcase
        end
      end
    end
  end

  // Lamp drive; registered so lamps never glitch
  // Order of precedence: supply state, then mode, then fault class.
  // Registering costs one cycle of latency but keeps combinational
  // hazards off the pins that drive the lamp transistors.
  // The second port lamp is forced dark on single-channel builds.
  // Point lamps show logic state, not the field voltage.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_indicator          <= 1'b0;
      run_indicator            <= 1'b0;
      fault_indicator          <= 1'b0;
      force_indicator          <= 1'b0;
      battery_indicator        <= 1'b0;
      port0_activity_indicator <= 1'b0;
      port1_activity_indicator <= 1'b0;
      default_comm_indicator   <= 1'b0;
      input_indicators         <= {N_IN{1'b0}};
      output_indicators        <= {N_OUT{1'b0}};
    end else if (!lamps_live) begin
      // No line power or overloaded supply: everything dark
      power_indicator          <= 1'b0;
      run_indicator            <= 1'b0;
      fault_indicator          <= 1'b0;
      force_indicator          <= 1'b0;
      battery_indicator        <= 1'b0;
      port0_activity_indicator <= 1'b0;
      port1_activity_indicator <= 1'b0;
      default_comm_indicator   <= 1'b0;
      input_indicators         <= {N_IN{1'b0}};
      output_indicators        <= {N_OUT{1'b0}};
    end else begin
      power_indicator <= 1'b1;
      // Remote run lights the lamp even outside local run mode.
      if (mode_state == `MODE_RUN || remote_run_mode) begin
        run_indicator <= 1'b1;
      end else if (mm_transfer) begin
        run_indicator <= flash_q;
      end else begin
        run_indicator <= 1'b0;
      end
      // Hardware class outranks user fault flashing
      // Steady red for hardware or critical faults, flashing red for a
      // halted user program, dark otherwise.
      if (hard_fault) begin
        fault_indicator <= 1'b1;
      end else if (major_error_halted_flag) begin
        fault_indicator <= flash_q;
      end else begin
        fault_indicator <= 1'b0;
      end
      // Plain levels: force, battery, default comm and points
      force_indicator          <= force_count_nz;
      battery_indicator        <= battery_low;
      port0_activity_indicator <= port0_active & flash_q;
      port1_activity_indicator <= (DUAL_PORT != 0) & port1_active & flash_q;
      default_comm_indicator   <= default_comm_ch0;
      input_indicators         <= in_sync_q;
      output_indicators        <= output_points;
    end
  end

endmodule // status_indicator_fault_logic

// File: test/sifl_checker.sv
/* Checker for the indicator and fault block.
   Sees only the top ports; bound at the foot of this file. */
`timescale 1ns/1ps
module sifl_checker #(
  parameter FLASH_HALF = 4  // Flash half period
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        power_good,
  input wire logic        supply_overload,
  input wire logic        hw_error,
  input wire logic        force_count_nz,
  input wire logic        battery_low,
  input wire logic        port0_active,
  input wire logic        remote_run_mode,
  input wire logic        run_request,
  input wire logic        major_fault,
  input wire logic        major_fault_user,
  input wire logic        power_indicator,
  input wire logic        run_indicator,
  input wire logic        fault_indicator,
  input wire logic        force_indicator,
  input wire logic        battery_indicator,
  input wire logic        port0_activity_indicator,
  input wire logic        major_error_halted_flag,
  input wire logic        user_fault_call,
  input wire logic [1:0]  mode_state,
  input wire logic        run_refused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire pwr_ok = power_good & ~supply_overload;  // Supply usable
  // Fault event and its recorded outcome
  sequence fault_ev; $past(rst_n) && major_fault; endsequence
  sequence fault_seen; major_error_halted_flag && mode_state == 2'h3; endsequence
  pwr_lamp_a: assert property ($past(rst_n) |-> power_indicator == $past(pwr_ok))
    else $error("power lamp mismatch");
  force_lamp_a: assert property ($past(rst_n) |-> force_indicator == $past(force_count_nz & pwr_ok))
    else $error("force lamp mismatch");
  batt_lamp_a: assert property ($past(rst_n) |-> battery_indicator == $past(battery_low & pwr_ok))
    else $error("battery lamp mismatch");
  run_remote_a: assert property ($past(rst_n) && $past(remote_run_mode & pwr_ok) |-> run_indicator)
    else $error("run lamp dark in remote run");
  hw_fault_a: assert property ($past(rst_n) && $past(hw_error & pwr_ok) |-> fault_indicator && power_indicator)
    else $error("hardware fault lamps wrong");
  fault_rec_a: assert property (fault_ev |=> fault_seen)
    else $error("major fault not recorded");
  refuse_run_a: assert property (run_request && major_error_halted_flag |-> run_refused ##1 mode_state != 2'h1)
    else $error("run entry not refused");
  user_call_a: assert property (fault_ev |=> user_fault_call == $past(major_fault_user && mode_state[1] != mode_state[0]))
    else $error("user subroutine dispatch wrong");
  stray_call_a: assert property ($past(rst_n) && !major_fault |=> !user_fault_call)
    else $error("stray subroutine call");
  port_lamp_a: assert property (!$past(port0_active) |-> !port0_activity_indicator)
    else $error("port lamp lit while idle");
endmodule  // sifl_checker

bind status_indicator_fault_logic sifl_checker #(.FLASH_HALF(FLASH_HALF)) chk (
  .clk(clk), .rst_n(rst_n), .power_good(power_good), .supply_overload(supply_overload), .hw_error(hw_error),
  .force_count_nz(force_count_nz), .battery_low(battery_low), .port0_active(port0_active),
  .remote_run_mode(remote_run_mode), .run_request(run_request), .major_fault(major_fault),
  .major_fault_user(major_fault_user), .power_indicator(power_indicator), .run_indicator(run_indicator),
  .fault_indicator(fault_indicator), .force_indicator(force_indicator), .battery_indicator(battery_indicator),
  .port0_activity_indicator(port0_activity_indicator), .major_error_halted_flag(major_error_halted_flag),
  .user_fault_call(user_fault_call), .mode_state(mode_state), .run_refused(run_refused));

// File: test/lamp_watch.sv
/* Operator view of one lamp: length of its last completed lit or dark spell.
   Assumes the lamp is a registered level on clk. */
`timescale 1ns/1ps
module lamp_watch (
  input wire logic clk,
  input wire logic lamp,
  output int       half
);
  int   run_q = 0;      // Cycles in current spell
  logic last_q = 1'b0;  // Lamp level last cycle
  // Spell counter; a steady lamp leaves half untouched
  always @(posedge clk) begin
    if (lamp !== last_q) begin
      half <= run_q;
      run_q <= 1;
    end else begin
      run_q <= run_q + 1;
    end
    last_q <= lamp;
  end
endmodule  // lamp_watch

// File: test/status_indicator_fault_logic_bench.sv
/* Self-checking bench for the indicator and fault block.
   Assumes a shortened flash period; lamp spells are read through lamp_watch. */
`timescale 1ns/1ps
module status_indicator_fault_logic_bench;
  localparam HALF = 4;  // Short flash half period keeps the run brief
  logic clk = 0, rst_n = 0, pg = 0, ovl = 0, hwe = 0, crit = 0, frc = 0, bat = 0, p0 = 0, p1 = 0;
  logic dcom = 0, mmt = 0, rrm = 0, runq = 0, mf = 0, mfu = 0, mfr = 0, fsp = 0, fob = 0, mbb = 0, hclr = 0, sdone = 0;
  logic tstq = 0, prgq = 0, cwr = 0, hset = 0, ufc, p1_l;
  logic [15:0] ipts = 0, fc = 0, cwd = 0, code, in_l;
  logic [11:0] opts = 0, out_l;
  logic [1:0]  mode;
  logic        pwr_l, run_l, flt_l, frc_l, bat_l, p0_l, dc_l, halted, refused, inrange;
  int          run_half, flt_half, p0_half, p1_half, n_fail = 0, compares = 0;
  always #2.5 clk = ~clk;  // 200 MHz
  status_indicator_fault_logic #(.FLASH_HALF(HALF)) dut (.clk(clk), .rst_n(rst_n), .power_good(pg),
    .supply_overload(ovl), .hw_error(hwe), .critical_fault(crit), .force_count_nz(frc), .battery_low(bat),
    .port0_active(p0), .port1_active(p1), .default_comm_ch0(dcom), .mm_transfer(mmt), .input_points(ipts),
    .output_points(opts), .remote_run_mode(rrm), .run_request(runq), .test_request(tstq), .program_request(prgq),
    .major_fault(mf), .major_fault_user(mfu), .major_fault_recoverable(mfr), .fault_code(fc),
    .fault_still_present(fsp), .fault_override_bit(fob), .mode_behavior_bit(mbb), .code_wr(cwr),
    .code_wr_data(cwd), .halted_set(hset), .halted_clr(hclr), .subroutine_done(sdone),
    .power_indicator(pwr_l), .run_indicator(run_l), .fault_indicator(flt_l), .force_indicator(frc_l),
    .battery_indicator(bat_l), .port0_activity_indicator(p0_l), .port1_activity_indicator(p1_l),
    .default_comm_indicator(dc_l), .input_indicators(in_l), .output_indicators(out_l), .major_error_code(code),
    .major_error_halted_flag(halted), .user_fault_call(ufc), .mode_state(mode), .run_refused(refused),
    .user_code_in_range(inrange));
  lamp_watch run_w (.clk(clk), .lamp(run_l), .half(run_half));
  lamp_watch flt_w (.clk(clk), .lamp(flt_l), .half(flt_half));
  lamp_watch p0_w (.clk(clk), .lamp(p0_l), .half(p0_half));
  lamp_watch p1_w (.clk(clk), .lamp(p1_l), .half(p1_half));
  task step(input int n); repeat (n) @(posedge clk); #1; endtask
  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Power cycle: reset held three cycles
  task boot; rst_n = 0; step(3); rst_n = 1; step(2); endtask
  // Bounded wait on the mode register
  task wait_mode(input logic [1:0] m);
    for (int i = 0; i < 10 && mode !== m; i++) step(1);
    if (mode !== m) begin n_fail++; summarize(); end
  endtask
  task pulse_run; runq = 1; step(1); runq = 0; endtask
  task t_lamps;
    pg = 1; frc = 1; bat = 1; dcom = 1; rrm = 1; p0 = 1; p1 = 1; ipts = 16'hA5C3; opts = 12'h5A1; step(4);
    chk("lamps on", {pwr_l, run_l, frc_l, bat_l, dc_l, in_l, out_l}, {5'h1F, 16'hA5C3, 12'h5A1});
    frc = 0; bat = 0; dcom = 0; rrm = 0; ipts = 0; opts = 0; step(4);
    chk("lamps off", {run_l, frc_l, bat_l, dc_l, in_l, out_l}, 0);
    mmt = 1; step(20); chk("transfer flash", HALF, run_half); mmt = 0;
    chk("port0 flash", HALF, p0_half);
    chk("port1 flash", HALF, p1_half);
    frc = 1; ovl = 1; step(4); chk("all dark", {pwr_l, run_l, frc_l, p0_l, dc_l}, 0); ovl = 0; frc = 0;
    hwe = 1; step(2); chk("hw lamps", {pwr_l, flt_l}, 2'h3); hwe = 0;
    crit = 1; step(2); chk("critical lamp", flt_l, 1); crit = 0; p0 = 0; p1 = 0; step(2);
    $display("test lamps done");
  endtask
  task t_user_fault;
    boot(); pulse_run(); wait_mode(2'h1);
    mf = 1; mfu = 1; mfr = 1; fc = 16'hFF05; step(1); mf = 0;
    chk("sub call", ufc, 1);
    step(1);
    chk("fault record", {halted, mode, code, inrange}, {1'b1, 2'h3, 16'hFF05, 1'b1});
    runq = 1; #1; chk("refused", refused, 1); step(1); runq = 0; step(1); chk("mode held", mode, 2'h3);
    step(16); chk("fault flash", HALF, flt_half);
    hwe = 1; step(1);
    repeat (10) begin step(1); chk("hw outranks", flt_l, 1); end
    hwe = 0; hclr = 1; step(1); hclr = 0; sdone = 1; step(1); sdone = 0; wait_mode(2'h1);
    chk("flag cleared", halted, 0);
    $display("test user fault done");
  endtask
  task t_boot;
    mf = 1; mfu = 0; fc = 16'h0012; step(1); mf = 0;
    chk("no sub call", ufc, 0);
    step(1); chk("system fault", mode, 2'h3);
    fob = 1; mbb = 1; boot(); chk("override run", {halted, mode}, 3'h1);
    fsp = 1; boot(); chk("persisting", mode, 2'h3); fsp = 0;
    mbb = 0; boot(); chk("override prog", {halted, mode}, 3'h0); fob = 0;
    $display("test boot done");
  endtask
  task t_soft;
    tstq = 1; step(1); tstq = 0; chk("test entry", mode, 2'h2);
    prgq = 1; step(1); prgq = 0; chk("program entry", mode, 2'h0);
    cwr = 1; cwd = 16'hFF0A; step(1); cwr = 0; hset = 1; step(1); hset = 0;
    chk("soft fault", {halted, mode, code, inrange, ufc}, {1'b1, 2'h3, 16'hFF0A, 1'b1, 1'b0});
    $display("test soft fault done");
  endtask
  initial begin
    step(3); rst_n = 1; step(2);
    t_lamps();
    t_user_fault();
    t_boot();
    t_soft();
    summarize();
  end
endmodule  // status_indicator_fault_logic_bench
